// file: ihc_host_model.sv
// host microprocessor model on the far side of the eight-bit port
`timescale 1ns/1ps
module ihc_host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_bus,
   input  wire logic       i_oe,
   output logic            o_wr_n,
   output logic            o_rd_n,
   output logic      [2:0] o_addr,
   output logic      [7:0] o_data
);
   initial begin
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_addr = 3'h0;
      o_data = 8'h00;
   end

   // ----------------------------------------------------------------
   // bus cycles, all changes at the falling edge
   // ----------------------------------------------------------------
   task automatic wr_byte(input logic [2:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_data = d;
      o_wr_n = 1'b0;
      @(negedge i_clk);
      o_wr_n = 1'b1;
      @(negedge i_clk);
      o_data = ~d; // released bus must not keep the old byte
   endtask : wr_byte

   task automatic load_word(input logic [31:0] w, input logic [7:0] dst);
      repeat (4) @(negedge i_clk);
      wr_byte(3'h0, w[7:0]);
      wr_byte(3'h1, w[15:8]);
      wr_byte(3'h2, w[23:16]);
      wr_byte(3'h3, w[31:24]);
      wr_byte(3'h4, dst);
   endtask : load_word

   task automatic set_source(input logic [2:0] c);
      wr_byte(3'h5, {5'h1f, c});
   endtask : set_source

   task automatic rd_byte(input logic [2:0] a, output logic [7:0] d, output logic oe);
      @(negedge i_clk);
      o_addr = a;
      o_rd_n = 1'b0;
      repeat (3) @(negedge i_clk);
      d      = i_bus;
      oe     = i_oe;
      o_rd_n = 1'b1;
      repeat (3) @(negedge i_clk);
   endtask : rd_byte
endmodule : ihc_host_model

// file: ihc_host_port.sv
// eight-bit indirect host port: holding bytes, transfers and reads
`timescale 1ns/1ps
module ihc_host_port
   import ihc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_wr_n,
   input  wire logic        i_rd_n,
   input  wire logic [2:0]  i_addr,
   input  wire logic [7:0]  i_data,
   output logic      [7:0]  o_data,
   output logic             o_data_oe,
   input  wire logic        i_sync_input_one,
   input  wire logic        i_sync_input_two,
   input  wire logic [31:0] i_src_iq,
   input  wire logic [31:0] i_src_magph,
   input  wire logic [15:0] i_src_freq,
   input  wire logic [31:0] i_src_agc,
   input  wire logic [23:0] i_level_det,
   input  wire logic [2:0]  i_fifo_depth,
   input  wire logic        i_fifo_empty,
   input  wire logic        i_fifo_full,
   input  wire logic        i_threshold_ready_n,
   input  wire logic        i_integ_done,
   output logic             o_fe_load,
   output logic             o_be_load,
   output logic      [7:0]  o_cfg_addr,
   output logic      [31:0] o_cfg_data,
   output logic      [31:0] o_gain_active,
   output logic      [31:0] o_nco_active
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] idx);
      word_byte = w[{idx, 3'h0} +: 8];
   endfunction : word_byte

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic        wr_n_r;
   logic        rd_n_r;
   logic [7:0]  hold_r [4];
   logic [7:0]  dest_r;
   logic [2:0]  rsrc_r;
   logic        xfer_start;
   logic        xfer_fire;
   logic        wr_rise;
   logic        rd_fall;
   logic [31:0] hold_word;
   logic        gain_sync_r;
   logic        nco_sync_r;
   logic        gain_pend_r;
   logic [31:0] nco_hold_r;
   logic        nco_pend_r;
   logic [7:0]  rd_byte;

   assign wr_rise    = !wr_n_r && i_wr_n;
   assign rd_fall    = rd_n_r && !i_rd_n;
   assign xfer_start = wr_rise && (i_addr == ADDR_DEST);
   assign hold_word  = {hold_r[3], hold_r[2], hold_r[1], hold_r[0]};

   // ----------------------------------------------------------------
   // strobe edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_n_r <= 1'b1;
         rd_n_r <= 1'b1;
      end else begin
         wr_n_r <= i_wr_n;
         rd_n_r <= i_rd_n;
      end
   end

   // ----------------------------------------------------------------
   // host writes; values persist until the host writes again
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            hold_r[i] <= BYTE_ZERO;
         end
         dest_r <= BYTE_ZERO;
         rsrc_r <= RSRC_IQ;
      end else if (wr_rise) begin
         if (i_addr <= ADDR_HOLD3) begin
            hold_r[i_addr[1:0]] <= i_data;
         end else if (i_addr == ADDR_DEST) begin
            dest_r <= i_data;
         end else if (i_addr == ADDR_RSEL) begin
            rsrc_r <= i_data[2:0];
         end
      end
   end

   ihc_xfer_delay u_delay (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_start   (xfer_start),
      .o_fire    (xfer_fire)
   );

   // ----------------------------------------------------------------
   // transfer to the destination domain
   // ----------------------------------------------------------------
   // one clock here: the domain choice picks which load strobe fires,
   // the receiving register file retimes it into its own clock
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_fe_load  <= 1'b0;
         o_be_load  <= 1'b0;
         o_cfg_addr <= BYTE_ZERO;
         o_cfg_data <= WORD_ZERO;
      end else begin
         o_fe_load <= xfer_fire && !dest_r[DEST_DOM_BIT];
         o_be_load <= xfer_fire && dest_r[DEST_DOM_BIT];
         if (xfer_fire) begin
            o_cfg_addr <= dest_r;
            o_cfg_data <= hold_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // shadow copies of the sync enables
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         gain_sync_r <= 1'b0;
         nco_sync_r  <= 1'b0;
      end else if (xfer_fire) begin
         if (dest_r == DEST_CW8) begin
            gain_sync_r <= hold_word[GAIN_SYNC_BIT];
         end
         if (dest_r == DEST_CW0) begin
            nco_sync_r <= hold_word[NCO_SYNC_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // gain: direct, or armed and moved from holding on sync two
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_gain_active <= WORD_ZERO;
         gain_pend_r   <= 1'b0;
      end else if (xfer_fire && dest_r == DEST_GAIN && !gain_sync_r) begin
         o_gain_active <= hold_word;
         gain_pend_r   <= 1'b0;
      end else if (xfer_fire && dest_r == DEST_GAIN) begin
         gain_pend_r <= 1'b1;
      end else if (gain_pend_r && i_sync_input_two) begin
         // reads the holding bytes at sync time, so they must not be reloaded meanwhile
         o_gain_active <= hold_word;
         gain_pend_r   <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // carrier frequency: dedicated holding register, moved on sync one
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         nco_hold_r   <= WORD_ZERO;
         nco_pend_r   <= 1'b0;
         o_nco_active <= WORD_ZERO;
      end else if (xfer_fire && dest_r == DEST_NCO) begin
         nco_hold_r <= hold_word;
         nco_pend_r <= nco_sync_r;
         if (!nco_sync_r) begin
            o_nco_active <= hold_word;
         end
      end else if (nco_pend_r && i_sync_input_one) begin
         o_nco_active <= nco_hold_r;
         nco_pend_r   <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read byte selection
   // ----------------------------------------------------------------
   always_comb begin
      rd_byte = BYTE_ZERO;
      if (i_addr == RADDR_STAT) begin
         rd_byte = BYTE_ZERO;
         rd_byte[ST_DEPTH_LSB +: 3] = i_fifo_depth;
         rd_byte[ST_EMPTY]          = i_fifo_empty;
         rd_byte[ST_FULL]           = i_fifo_full;
         rd_byte[ST_READY_N]        = i_threshold_ready_n;
         rd_byte[ST_DONE]           = i_integ_done;
      end else begin
         case (rsrc_r)
            RSRC_IQ:    if (!i_addr[2]) rd_byte = word_byte(i_src_iq, i_addr[1:0]);
            RSRC_MAGPH: if (!i_addr[2]) rd_byte = word_byte(i_src_magph, i_addr[1:0]);
            RSRC_FREQ:  if (i_addr[2:1] == 2'h0) rd_byte = word_byte({16'h0000, i_src_freq},
                                                                      i_addr[1:0]);
            RSRC_LEVEL: if (i_addr <= ADDR_HOLD2) begin
               rd_byte = word_byte({8'h00, i_level_det}, i_addr[1:0]);
            end
            RSRC_AGC:   if (!i_addr[2]) rd_byte = word_byte(i_src_agc, i_addr[1:0]);
            default:    rd_byte = BYTE_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read drive: byte latched at the falling read strobe
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_data    <= BYTE_ZERO;
         o_data_oe <= 1'b0;
      end else if (rd_fall) begin
         o_data    <= rd_byte;
         o_data_oe <= 1'b1;
      end else if (i_rd_n) begin
         o_data_oe <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_dest_write;
      wr_rise && i_addr == ADDR_DEST;
   endsequence

   sequence s_quiet3;
      !xfer_start [*3];
   endsequence

   a_hold_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_rise && i_addr == ADDR_HOLD1 |=> hold_r[1] == $past(i_data))
      else $error("holding byte one not captured");

   a_dest_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_dest_write |=> dest_r == $past(i_data))
      else $error("destination address not captured");

   a_xfer_timing: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_dest_write ##1 s_quiet3 |=> ##1 ((o_fe_load || o_be_load) && o_cfg_data == hold_word))
      else $error("transfer not on fourth clock");

   a_xfer_domain: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_be_load |-> !o_fe_load && o_cfg_addr[DEST_DOM_BIT])
      else $error("transfer in wrong domain");

   a_rsrc_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_rise && i_addr == ADDR_RSEL |=> rsrc_r == $past(i_data[2:0]))
      else $error("read source code not stored");

   a_status_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_fall && i_addr == RADDR_STAT |=> o_data_oe && o_data[ST_EMPTY] == $past(i_fifo_empty)
         && o_data[ST_DEPTH_LSB +: 3] == $past(i_fifo_depth))
      else $error("status byte wrong");

   a_level_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_fall && rsrc_r == RSRC_LEVEL && i_addr == ADDR_HOLD2
         |=> o_data == $past(i_level_det[23:16]))
      else $error("level detector high byte wrong");

   a_gain_gated: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      gain_pend_r && !i_sync_input_two && !xfer_fire |=> $stable(o_gain_active))
      else $error("gain moved without sync two");

   a_nco_sync: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      nco_pend_r && i_sync_input_one && !xfer_fire |=> o_nco_active == $past(nco_hold_r))
      else $error("carrier frequency not moved on sync one");

   a_hold0_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_rise && i_addr == ADDR_HOLD0 |=> hold_r[0] == $past(i_data))
      else $error("holding byte zero not captured");

   a_hold3_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_rise && i_addr == ADDR_HOLD3 |=> hold_r[3] == $past(i_data))
      else $error("holding byte three not captured");

   a_hold_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !wr_rise |=> $stable(hold_word) && $stable(rsrc_r))
      else $error("holding bytes or read code changed without a write");

   a_load_single: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_fe_load || o_be_load) |=> !(o_fe_load || o_be_load))
      else $error("load pulse longer than one clock");

   a_fe_domain: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_fe_load |-> !o_be_load && !o_cfg_addr[DEST_DOM_BIT])
      else $error("front-end load for a back-end destination");

   a_rd_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_rd_n |=> !o_data_oe)
      else $error("data bus still driven after read strobe high");

   a_status_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_fall && i_addr == RADDR_STAT |=> o_data[ST_FULL] == $past(i_fifo_full)
         && o_data[ST_READY_N] == $past(i_threshold_ready_n)
         && o_data[ST_DONE] == $past(i_integ_done))
      else $error("status flag bits wrong");

   a_gain_direct: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      xfer_fire && dest_r == DEST_GAIN && !gain_sync_r |=> o_gain_active == $past(hold_word))
      else $error("gain not loaded directly with sync off");

   a_nco_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      xfer_fire && dest_r == DEST_NCO |=> nco_hold_r == $past(hold_word))
      else $error("carrier frequency holding not loaded");
endmodule : ihc_host_port

// file: ihc_pkg.sv
// constants and layouts for the indirect host configuration port
// ----------------------------------------------------------------
// How it works
// - four byte writes at addresses 0..3 build bits 7-0 up to 31-24 of a word
// - data and address lines are captured on the rising edge of the write strobe
// - writing address 4 makes a clocked pulse copying holding bytes to destination
// - all eight bits written to address 4 form the destination address
// - the transfer lands on the fourth clock after the destination write
// - transfer goes to the front-end or back-end domain by destination
// - with word 8 bit 29 set, gain loads only on sync input two
// - with word 0 bit 20 set, carrier frequency loads on sync input one
// - address lines pick a byte, driven on the falling edge of read strobe
// - read address 111 ignores the code and returns the status byte
// - status holds depth 6:4, empty 3, full 2, ready_n 1, done 0
// - code 100 returns the level detector low, middle, high bytes
// ----------------------------------------------------------------
package ihc_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned XFER_CYCLES   = 4;
   localparam logic [2:0]  XFER_CNT_INIT = 3'h4;
   localparam logic [2:0]  XFER_CNT_FIRE = 3'h1;
   localparam logic [2:0]  XFER_CNT_IDLE = 3'h0;

   // ----------------------------------------------------------------
   // host addresses
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_HOLD0  = 3'h0;
   localparam logic [2:0] ADDR_HOLD1  = 3'h1;
   localparam logic [2:0] ADDR_HOLD2  = 3'h2;
   localparam logic [2:0] ADDR_HOLD3  = 3'h3;
   localparam logic [2:0] ADDR_DEST   = 3'h4;
   localparam logic [2:0] ADDR_RSEL   = 3'h5;
   localparam logic [2:0] RADDR_STAT  = 3'h7;

   // ----------------------------------------------------------------
   // read-source codes
   // ----------------------------------------------------------------
   localparam logic [2:0] RSRC_IQ     = 3'h0;
   localparam logic [2:0] RSRC_MAGPH  = 3'h1;
   localparam logic [2:0] RSRC_FREQ   = 3'h2;
   localparam logic [2:0] RSRC_LEVEL  = 3'h4;
   localparam logic [2:0] RSRC_AGC    = 3'h5;

   // ----------------------------------------------------------------
   // destination addresses and control bits
   // ----------------------------------------------------------------
   localparam logic [7:0] DEST_CW0       = 8'h00;
   localparam logic [7:0] DEST_CW8       = 8'h08;
   localparam logic [7:0] DEST_GAIN      = 8'h0a;
   localparam logic [7:0] DEST_NCO       = 8'h01;
   localparam int unsigned DEST_DOM_BIT  = 7;
   localparam int unsigned GAIN_SYNC_BIT = 29;
   localparam int unsigned NCO_SYNC_BIT  = 20;

   // ----------------------------------------------------------------
   // status byte layout
   // ----------------------------------------------------------------
   localparam int unsigned ST_DEPTH_LSB = 4;
   localparam int unsigned ST_EMPTY     = 3;
   localparam int unsigned ST_FULL      = 2;
   localparam int unsigned ST_READY_N   = 1;
   localparam int unsigned ST_DONE      = 0;

   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
endpackage : ihc_pkg

// file: ihc_xfer_delay.sv
// counts the clocks between a destination write and its transfer
`timescale 1ns/1ps
module ihc_xfer_delay
   import ihc_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_start,
   output logic      o_fire
);
   logic [2:0] cnt_r;

   // ----------------------------------------------------------------
   // countdown; a new start restarts it, the host must not do that
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_r <= XFER_CNT_IDLE;
      end else if (i_start) begin
         cnt_r <= XFER_CNT_INIT;
      end else if (cnt_r != XFER_CNT_IDLE) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end

   assign o_fire = (cnt_r == XFER_CNT_FIRE);

   a_fire_after_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_start ##1 !i_start [*3] |=> o_fire)
      else $error("transfer pulse not on fourth clock after start");
endmodule : ihc_xfer_delay

// file: indirect_host_config_port_tb_top.sv
// self-checking bench for the indirect host configuration port
`timescale 1ns/1ps
module indirect_host_config_port_tb_top import ihc_pkg::*;;
   logic        clk;
   logic        rst;
   logic        sync1;
   logic        sync2;
   logic [31:0] iq;
   logic [31:0] magph;
   logic [15:0] freq;
   logic [31:0] agc;
   logic [23:0] level;
   logic [2:0]  depth;
   logic        empty;
   logic        full;
   logic        rdy_n;
   logic        done;
   logic        wr_n;
   logic        rd_n;
   logic [2:0]  addr;
   logic [7:0]  hdata;
   logic [7:0]  ddata;
   logic        oe;
   logic        fe_load;
   logic        be_load;
   logic [7:0]  cfg_addr;
   logic [31:0] cfg_data;
   logic [31:0] gain;
   logic [31:0] nco;
   wire logic [7:0] bus;
   int          fails;
   int          n_checks;

   assign bus = (oe === 1'b1) ? ddata : hdata;

   ihc_host_model host (.i_clk(clk), .i_bus(bus), .i_oe(oe), .o_wr_n(wr_n), .o_rd_n(rd_n),
      .o_addr(addr), .o_data(hdata));

   ihc_host_port dut (.i_clk(clk), .i_sys_rst(rst), .i_wr_n(wr_n), .i_rd_n(rd_n),
      .i_addr(addr), .i_data(bus), .o_data(ddata), .o_data_oe(oe),
      .i_sync_input_one(sync1), .i_sync_input_two(sync2), .i_src_iq(iq),
      .i_src_magph(magph), .i_src_freq(freq), .i_src_agc(agc), .i_level_det(level),
      .i_fifo_depth(depth), .i_fifo_empty(empty), .i_fifo_full(full),
      .i_threshold_ready_n(rdy_n), .i_integ_done(done), .o_fe_load(fe_load),
      .o_be_load(be_load), .o_cfg_addr(cfg_addr), .o_cfg_data(cfg_data),
      .o_gain_active(gain), .o_nco_active(nco));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   function automatic logic [7:0] exp_rd(input logic [2:0] c, input logic [2:0] a);
      if (a == RADDR_STAT) return {1'b0, depth, empty, full, rdy_n, done};
      case (c)
         RSRC_IQ:    return iq[15:8];
         RSRC_MAGPH: return magph[15:8];
         RSRC_FREQ:  return freq[15:8];
         RSRC_LEVEL: return level[15:8];
         RSRC_AGC:   return agc[15:8];
         default:    return 8'h00;
      endcase
   endfunction : exp_rd

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       o;
      host.rd_byte(a, d, o);
      chk("rd_oe", 32'h1, {31'h0, o});
      chk("rd_byte", {24'h0, e}, {24'h0, d});
      chk("rd_release", 32'h0, {31'h0, oe});
   endtask : rd_chk

   // pulse must appear once, at the fourth edge after the strobe rise is seen
   task automatic xfer(input logic [31:0] w, input logic [7:0] dst);
      int k;
      int hit;
      int n;
      hit = 0;
      n   = 0;
      host.load_word(w, dst);
      for (k = 2; k <= 9; k++) begin
         @(negedge clk);
         if ((fe_load | be_load) === 1'b1) begin
            n++;
            hit = k;
            chk("cfg_addr", {24'h0, dst}, {24'h0, cfg_addr});
            chk("cfg_data", w, cfg_data);
            chk("load_domain", {31'h0, dst[7]}, {31'h0, be_load});
            chk("fe_domain", {31'h0, !dst[7]}, {31'h0, fe_load});
         end
      end
      chk("load_count", 32'h1, n);
      chk("load_cycle", 32'h5, hit);
   endtask : xfer

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_sync_moves();
      xfer(32'h0018_d038, DEST_CW0);
      xfer(32'ha5c3_0f96, 8'h89);
      xfer(32'h1234_5678, DEST_NCO);
      chk("nco_armed", 32'h0, nco);
      sync1 = 1'b1;
      @(negedge clk);
      sync1 = 1'b0;
      repeat (2) @(negedge clk);
      chk("nco_moved", 32'h1234_5678, nco);
      xfer(32'h2000_0000, DEST_CW8);
      xfer(32'h0000_0abc, DEST_GAIN);
      repeat (3) @(negedge clk);
      chk("gain_armed", 32'h0, gain);
      sync2 = 1'b1;
      @(negedge clk);
      sync2 = 1'b0;
      repeat (2) @(negedge clk);
      chk("gain_moved", 32'h0000_0abc, gain);
      xfer(32'h0000_0000, DEST_CW8);
      xfer(32'h0000_0123, DEST_GAIN);
      chk("gain_direct", 32'h0000_0123, gain);
      xfer(32'h0000_0000, DEST_CW0);
      xfer(32'h0765_4321, DEST_NCO);
      chk("nco_direct", 32'h0765_4321, nco);
   endtask : t_sync_moves

   task automatic t_read_codes();
      logic [3:0] c;
      for (c = 4'h0; c < 4'h8; c++) begin
         host.set_source(c[2:0]);
         rd_chk(3'h1, exp_rd(c[2:0], 3'h1));
         rd_chk(RADDR_STAT, exp_rd(c[2:0], RADDR_STAT));
      end
   endtask : t_read_codes

   task automatic t_level_bytes();
      host.set_source(RSRC_LEVEL);
      host.wr_byte(3'h6, 8'h03);
      rd_chk(3'h0, 8'hf5);
      rd_chk(3'h2, 8'h32);
      rd_chk(3'h3, 8'h00);
   endtask : t_level_bytes

   task automatic end_sim();
      if (fails == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   initial begin
      clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end

   // watchdog: whole run needs well under 2000 clocks
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end

   initial begin
      fails    = 0;
      n_checks = 0;
      rst      = 1'b1;
      sync1    = 1'b0;
      sync2    = 1'b0;
      iq       = 32'h4433_2211;
      magph    = 32'h8877_6655;
      freq     = 16'hbbaa;
      agc      = 32'hffee_ddcc;
      level    = 24'h32_1af5;
      depth    = 3'h5;
      empty    = 1'b0;
      full     = 1'b1;
      rdy_n    = 1'b0;
      done     = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      chk("reset_data", 32'h0, cfg_data);
      chk("reset_oe", 32'h0, {31'h0, oe});
      t_sync_moves();
      t_read_codes();
      t_level_bytes();
      end_sim();
   end
endmodule : indirect_host_config_port_tb_top
